/* core/uabw_pkg.sv */
// package for the auto-baud and wake-on-break block
package uabw_pkg;
	// register byte addresses, one 32-bit word each
	localparam logic [3:0] ADDR_CONTROL  = 4'h0;
	localparam logic [3:0] ADDR_DIVISOR  = 4'h4;
	localparam logic [3:0] ADDR_RX_BUF   = 4'h8;
	// control register bit positions
	localparam int BIT_ABD_EN   = 0;
	localparam int BIT_WAKE_EN  = 1;
	localparam int BIT_WIDE_SEL = 3;
	localparam int BIT_HS_SEL   = 4;
	localparam int BIT_RX_FLAG  = 5;
	localparam int BIT_RX_IDLE  = 6;
	localparam int BIT_OVF      = 7;
	// calibration counter starts at one
	localparam logic [15:0] DIV_START   = 16'h0001;
	localparam logic [15:0] DIV_RESET   = 16'h0000;
	localparam logic [7:0]  CTRL_RESET  = 8'h00;
	// calibration clock prescales: base/8 gives fosc/512, /128, /32
	localparam logic [8:0]  PRE_SLOW    = 9'h1FF;
	localparam logic [8:0]  PRE_MID     = 9'h07F;
	localparam logic [8:0]  PRE_FAST    = 9'h01F;
	localparam int          RISE_COUNT  = 5;
	// calibration sequencer states
	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0001,
		ST_START = 4'b0010,
		ST_WAIT1 = 4'b0100,
		ST_COUNT = 4'b1000
	} uabw_state_t;
endpackage

/* core/uabw_core.sv */
// auto-baud measurement and wake-on-break logic behind an avalon-mm slave
//
// Our own choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module uabw_core
	import uabw_pkg::*;
(
	input  wire logic        clk,              // 10 MHz system clock
	input  wire logic        rst_b,            // async reset, active low
	input  wire logic        receive_line,     // serial receive pin
	input  wire logic        async_mode,       // serial unit in asynchronous mode
	input  wire logic [3:0]  avs_address,      // byte address
	input  wire logic        avs_read,         // read request
	input  wire logic        avs_write,        // write request
	input  wire logic [31:0] avs_writedata,    // write data
	input  wire logic [3:0]  avs_byteenable,   // byte lanes
	output logic [31:0]      avs_readdata,     // read data
	output logic             avs_waitrequest,  // stall
	output logic             rx_hold_idle      // normal receiver held idle
);
	import uabw_pkg::*;

	logic        rx_meta;
	logic        rx_sync;
	logic        rx_prev;
	logic        autobaud_enable_bit;
	logic        wake_on_break_enable;
	logic        wide_divider_select;
	logic        high_speed_select;
	logic        receive_flag;
	logic        autobaud_overflow_flag;
	logic [15:0] divisor_pair;
	logic [8:0]  pre_cnt;
	logic [8:0]  pre_max;
	logic [2:0]  rise_cnt;
	logic        tick;
	logic        rise;
	logic        fall;
	logic        cal_done;
	logic        wake_event;
	logic        wr_ctrl;
	logic        rd_buf;
	logic        ack;
	uabw_state_t state;
	uabw_state_t next_state;

	// decode of a bus hit on one word
	function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
		hit = (a == off);
	endfunction

	// two-stage synchroniser, first stage feeds only the second
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rx_meta <= 1'b1;
			rx_sync <= 1'b1;
			rx_prev <= 1'b1;
		end
		else
		begin
			rx_meta <= receive_line;
			rx_sync <= rx_meta;
			rx_prev <= rx_sync;
		end
	end

	assign rise = rx_sync & ~rx_prev;
	assign fall = ~rx_sync & rx_prev;

	// one-cycle wait on every access keeps read data registered
	assign avs_waitrequest = (avs_read | avs_write) & ~ack;
	assign wr_ctrl = avs_write & ack & hit(avs_address, ADDR_CONTROL) & avs_byteenable[0];
	assign rd_buf  = avs_read & ack & hit(avs_address, ADDR_RX_BUF);

	// ack toggles so a held request sees exactly one wait cycle
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			ack <= 1'b0;
		else
			ack <= (avs_read | avs_write) & ~ack;
	end

	// read data; unmapped words read zero
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			avs_readdata <= 32'h0000_0000;
		else if (avs_read & ~ack)
		begin
			avs_readdata <= 32'h0000_0000;
			if (hit(avs_address, ADDR_CONTROL))
			begin
				avs_readdata[BIT_ABD_EN]   <= autobaud_enable_bit;
				avs_readdata[BIT_WAKE_EN]  <= wake_on_break_enable;
				avs_readdata[BIT_WIDE_SEL] <= wide_divider_select;
				avs_readdata[BIT_HS_SEL]   <= high_speed_select;
				avs_readdata[BIT_RX_FLAG]  <= receive_flag;
				avs_readdata[BIT_RX_IDLE]  <= (state == ST_IDLE) & rx_sync;
				avs_readdata[BIT_OVF]      <= autobaud_overflow_flag;
			end
			else if (hit(avs_address, ADDR_DIVISOR))
				avs_readdata[15:0] <= divisor_pair;
		end
	end

	// calibration prescale per select bits; base/8
	always_comb
	begin
		if (wide_divider_select & high_speed_select)
			pre_max = PRE_FAST;
		else if (wide_divider_select | high_speed_select)
			pre_max = PRE_MID;
		else
			pre_max = PRE_SLOW;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			pre_cnt <= 9'h000;
		else if (state != ST_COUNT || pre_cnt == pre_max)
			pre_cnt <= 9'h000;
		else
			pre_cnt <= pre_cnt + 9'h001;
	end

	assign tick = (state == ST_COUNT) && (pre_cnt == pre_max);

	// sequencer: wait for start bit, first rise, then four more rises
	always_comb
	begin
		next_state = state;
		case (state)
			ST_IDLE:
				if (autobaud_enable_bit && !wake_on_break_enable)
					next_state = ST_START;
			ST_START:
				if (!autobaud_enable_bit)
					next_state = ST_IDLE;
				else if (fall)
					next_state = ST_WAIT1;
			ST_WAIT1:
				if (!autobaud_enable_bit)
					next_state = ST_IDLE;
				else if (rise)
					next_state = ST_COUNT;
			ST_COUNT:
				if (!autobaud_enable_bit || cal_done)
					next_state = ST_IDLE;
			default:
				next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			state <= ST_IDLE;
		else
			state <= next_state;
	end

	// rising edges counted after the first one
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			rise_cnt <= 3'h0;
		else if (state != ST_COUNT)
			rise_cnt <= 3'h1;
		else if (rise)
			rise_cnt <= rise_cnt + 3'h1;
	end

	assign cal_done = (state == ST_COUNT) && rise && (rise_cnt == 3'(RISE_COUNT - 1));

	// divisor pair: 16-bit counter during calibration, else software word
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			divisor_pair <= DIV_RESET;
		else if (state == ST_WAIT1 && rise)
			divisor_pair <= DIV_START;
		else if (tick)
			divisor_pair <= divisor_pair + 16'h0001;
		else if (state == ST_IDLE && avs_write && ack && hit(avs_address, ADDR_DIVISOR))
		begin
			if (avs_byteenable[0])
				divisor_pair[7:0] <= avs_writedata[7:0];
			if (avs_byteenable[1])
				divisor_pair[15:8] <= avs_writedata[15:8];
		end
	end

	// overflow flag; wrap wins over a same-cycle clear
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			autobaud_overflow_flag <= 1'b0;
		else if (tick && divisor_pair == 16'hFFFF)
			autobaud_overflow_flag <= 1'b1;
		else if (wr_ctrl && !autobaud_enable_bit && !avs_writedata[BIT_OVF])
			autobaud_overflow_flag <= 1'b0;
	end

	// auto-baud enable: software sets, fifth edge clears
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			autobaud_enable_bit <= 1'b0;
		else if (cal_done)
			autobaud_enable_bit <= 1'b0;
		else if (wr_ctrl)
			autobaud_enable_bit <= avs_writedata[BIT_ABD_EN];
	end

	// wake only in async mode; falling edge is the event
	assign wake_event = wake_on_break_enable && async_mode && fall;

	// wake enable: software sets, rise ending the break clears
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			wake_on_break_enable <= 1'b0;
		else if (wake_on_break_enable && rise)
			wake_on_break_enable <= 1'b0;
		else if (wr_ctrl)
			wake_on_break_enable <= avs_writedata[BIT_WAKE_EN] & async_mode;
	end

	// select bits steer the prescale
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wide_divider_select <= 1'b0;
			high_speed_select   <= 1'b0;
		end
		else if (wr_ctrl)
		begin
			wide_divider_select <= avs_writedata[BIT_WIDE_SEL];
			high_speed_select   <= avs_writedata[BIT_HS_SEL];
		end
	end

	// receive flag; set wins over the buffer-read clear
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			receive_flag <= 1'b0;
		else if (cal_done || wake_event)
			receive_flag <= 1'b1;
		else if (rd_buf)
			receive_flag <= 1'b0;
	end

	// receiver stays idle while calibrating or waiting for wake;
	// the sequencer term covers the cycle after software aborts
	assign rx_hold_idle = autobaud_enable_bit | wake_on_break_enable | (state != ST_IDLE);

	// count advances only on calibration ticks
	div_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
		(state == ST_COUNT && !tick && !$past(state == ST_WAIT1)) |=> $stable(divisor_pair))
		else $error("divisor moved without a tick");
	cal_end_a: assert property (@(posedge clk) disable iff (!rst_b)
		cal_done |=> (!autobaud_enable_bit && receive_flag && state == ST_IDLE))
		else $error("calibration end did not clear enable and set flag");
	cnt_start_a: assert property (@(posedge clk) disable iff (!rst_b)
		(state == ST_WAIT1 && rise) |=> (divisor_pair == DIV_START))
		else $error("counter did not start at one");
	ovf_set_a: assert property (@(posedge clk) disable iff (!rst_b)
		(tick && divisor_pair == 16'hFFFF) |=> autobaud_overflow_flag)
		else $error("overflow not flagged");
	ovf_keep_a: assert property (@(posedge clk) disable iff (!rst_b)
		(autobaud_overflow_flag && autobaud_enable_bit) |=> autobaud_overflow_flag)
		else $error("overflow cleared while enabled");
	wake_flag_a: assert property (@(posedge clk) disable iff (!rst_b)
		wake_event |=> receive_flag)
		else $error("wake event did not set flag");
	wake_clr_a: assert property (@(posedge clk) disable iff (!rst_b)
		(wake_on_break_enable && rise) |=> !wake_on_break_enable)
		else $error("wake enable not cleared by rising edge");
	flag_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
		(receive_flag && !rd_buf) |=> receive_flag)
		else $error("receive flag cleared without buffer read");
	hold_idle_a: assert property (@(posedge clk) disable iff (!rst_b)
		(state != ST_IDLE) |-> rx_hold_idle)
		else $error("receiver not held idle during calibration");
	after_brk_a: assert property (@(posedge clk) disable iff (!rst_b)
		(state == ST_IDLE && wake_on_break_enable) |=> state == ST_IDLE)
		else $error("calibration began during break");
	fifth_a: assert property (@(posedge clk) disable iff (!rst_b)
		cal_done |-> (rise_cnt == 3'h4))
		else $error("calibration ended off the fifth edge");
	// rises two to four must leave the count running
	early_end_a: assert property (@(posedge clk) disable iff (!rst_b)
		(state == ST_COUNT && autobaud_enable_bit && rise && rise_cnt != 3'h4) |=> state == ST_COUNT)
		else $error("calibration ended before the fifth edge");
	// fast select pair must tick at the short prescale
	fast_pre_a: assert property (@(posedge clk) disable iff (!rst_b)
		(state == ST_COUNT && wide_divider_select && high_speed_select && pre_cnt == PRE_FAST) |-> tick)
		else $error("fast prescale did not tick");
	// slow select pair must not tick before the long prescale
	slow_pre_a: assert property (@(posedge clk) disable iff (!rst_b)
		(state == ST_COUNT && !wide_divider_select && !high_speed_select && pre_cnt != PRE_SLOW) |-> !tick)
		else $error("slow prescale ticked early");
	// software clear of overflow works once enable is low
	ovf_clr_a: assert property (@(posedge clk) disable iff (!rst_b)
		(wr_ctrl && !autobaud_enable_bit && !avs_writedata[BIT_OVF] && !tick) |=> !autobaud_overflow_flag)
		else $error("overflow clear ignored");
	// a plain enable write sets the auto-baud enable bit
	abd_set_a: assert property (@(posedge clk) disable iff (!rst_b)
		(wr_ctrl && avs_writedata[BIT_ABD_EN] && !cal_done) |=> autobaud_enable_bit)
		else $error("auto-baud enable write lost");
	// wake cannot be armed outside asynchronous mode
	async_wake_a: assert property (@(posedge clk) disable iff (!rst_b)
		(wr_ctrl && !async_mode) |=> !wake_on_break_enable)
		else $error("wake armed outside async mode");
endmodule

/* tb/uabw_remote_tx.sv */
// remote serial transmitter model driving the receive line
`timescale 1ns/1ps
module uabw_remote_tx
(
	input  wire logic clk,  // system clock
	output logic      line  // receive line, idle high
);
	// frame bits go out lsb first, each held bc clocks; line stays at the last bit
	task automatic frame(input logic [15:0] f, input int nb, input int bc);
		for (int i = 0; i < nb; i++)
		begin
			@(posedge clk);
			line <= f[i];
			repeat (bc - 1) @(posedge clk);
		end
	endtask

	// idle line is high before the first frame
	initial
		line = 1'b1;
endmodule

/* tb/testbench.sv */
// self-checking bench for the auto-baud and wake-on-break block
`timescale 1ns/1ps
module testbench;
	import uabw_pkg::*;
	logic        clk;
	logic        rst_b;
	logic        receive_line;
	logic        async_mode;
	logic [3:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [3:0]  avs_byteenable;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        rx_hold_idle;
	logic [31:0] q;
	logic [15:0] d;
	int          num_errors;
	int          n_tests;
	int          k;

	// design and far-end transmitter
	uabw_core uut (.clk(clk), .rst_b(rst_b), .receive_line(receive_line), .async_mode(async_mode),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .rx_hold_idle(rx_hold_idle));
	uabw_remote_tx far (.clk(clk), .line(receive_line));

	// 10 mhz clock
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			num_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one transfer, held until waitrequest low; idle edge first so strobes never glitch
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge clk);
		avs_read <= ~w;
		avs_write <= w;
		avs_address <= a;
		avs_writedata <= wd;
		do
		begin
			@(negedge clk);
			n++;
		end
		while (avs_waitrequest !== 1'b0 && n < 20);
		if (n >= 20)
			num_errors++;
		// waitrequest seen low, so this edge is where the slave takes the transfer
		@(posedge clk);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(q, exp);
	endtask

	// poll until the enable drops, bounded
	task automatic wait_done();
		int n;
		n = 0;
		do
		begin
			bus(1'b0, ADDR_CONTROL, 32'h0);
			n++;
		end
		while (q[BIT_ABD_EN] !== 1'b0 && n < 500);
		if (n >= 500)
			num_errors++;
	endtask

	// calibration clock divide per select pair
	function automatic int pre(input int m);
		return (m == 0) ? 512 : (m == 3) ? 32 : 128;
	endfunction

	function automatic logic [31:0] sel(input int m);
		return {27'h0, m[0], m[1], 3'h0};
	endfunction

	task automatic conclude();
		$display("tests=%0d errors=%0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// watchdog well above the longest calibration run
	initial
	begin
		repeat (50000) @(posedge clk);
		num_errors++;
		conclude();
	end

	// main sequence; bit time gives half a count of margin so the tick phase cannot flip it
	initial
	begin
		rst_b = 1'b0;
		async_mode = 1'b1;
		avs_address = 4'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hF;
		num_errors = 0;
		n_tests = 0;
		k = $urandom(52638);
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		rd(ADDR_CONTROL, 32'h40);
		rd(ADDR_DIVISOR, 32'h0);
		rd(4'hC, 32'h0);
		d = $urandom;
		bus(1'b1, ADDR_DIVISOR, {16'h0, d});
		avs_byteenable <= 4'h1;
		bus(1'b1, ADDR_DIVISOR, 32'h5AA5);
		avs_byteenable <= 4'hF;
		rd(ADDR_DIVISOR, {16'h0, d[15:8], 8'hA5});
		async_mode <= 1'b0;
		bus(1'b1, ADDR_CONTROL, 32'h2);
		rd(ADDR_CONTROL, 32'h40);
		async_mode <= 1'b1;
		// abort: enable off first, then the overflow clear
		bus(1'b1, ADDR_CONTROL, 32'h1);
		bus(1'b1, ADDR_CONTROL, 32'h0);
		bus(1'b1, ADDR_CONTROL, 32'h0);
		rd(ADDR_CONTROL, 32'h40);
		$display("register test done");
		for (int m = 0; m < 4; m++)
		begin
			k = $urandom_range(3, 1);
			bus(1'b1, ADDR_CONTROL, sel(m) | 32'h1);
			@(negedge clk);
			chk({31'h0, rx_hold_idle}, 32'h1);
			far.frame(16'h02AA, 10, pre(m) * (2 * k + 1) / 16);
			wait_done();
			rd(ADDR_CONTROL, sel(m) | 32'h60);
			@(negedge clk);
			chk({31'h0, rx_hold_idle}, 32'h0);
			rd(ADDR_DIVISOR, 32'(k + 1));
			rd(ADDR_RX_BUF, 32'h0);
			rd(ADDR_CONTROL, sel(m) | 32'h40);
			$display("calibration mode %0d done", m);
		end
		bus(1'b1, ADDR_CONTROL, 32'h1B);
		fork
			far.frame(16'h2000, 14, 40);
			begin
				repeat (200) @(posedge clk);
				rd(ADDR_CONTROL, 32'h3B);
			end
		join
		bus(1'b0, ADDR_CONTROL, 32'h0);
		chk(q & 32'hBF, 32'h39);
		rd(ADDR_RX_BUF, 32'h0);
		far.frame(16'h02AA, 10, 6);
		wait_done();
		rd(ADDR_CONTROL, 32'h78);
		rd(ADDR_DIVISOR, 32'h2);
		rd(ADDR_RX_BUF, 32'h0);
		$display("break then sync done");
		bus(1'b1, ADDR_CONTROL, 32'h2);
		far.frame(16'h02AA, 10, 20);
		rd(ADDR_CONTROL, 32'h60);
		rd(ADDR_RX_BUF, 32'h0);
		rd(ADDR_CONTROL, 32'h40);
		$display("fragment wake done");
		conclude();
	end
endmodule
